// ---- pcg_top.sv ----
// peripheral clock gating control with its register slave
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - gate bit one clocks the unit
// - gate bit zero stops the unit clock
// - access to unclocked unit gives bus fault
// - all gate bits reset to zero
// - run, sleep, deep-sleep sets by mode
// - sleep sets only with auto gating select
// - second register: ports, mac, phy bits
// - first register: serial, sync serial, two-wire
// - reserved bits read zero, ignore writes
// - second run register at offset 0x108
// - first register bits 16-19 gate timers
module pcg_top (
  // clock and reset
  input  wire  logic                       hclk,
  input  wire  logic                       hresetn,
  // ahb-lite slave
  input  wire  logic                       hsel,
  input  wire  logic [31:0]                haddr,
  input  wire  logic [1:0]                 htrans,
  input  wire  logic                       hwrite,
  input  wire  logic [2:0]                 hsize,
  input  wire  logic [31:0]                hwdata,
  input  wire  logic                       hready,
  output var   logic [31:0]                hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // power mode
  input  wire  logic                       sleep_mode,
  input  wire  logic                       deep_sleep_mode,
  // unit side
  input  wire  logic [pcg_pkg::UNIT_N-1:0] unit_access,
  output logic [pcg_pkg::UNIT_N-1:0]       unit_clk_en,
  output logic                             bus_fault,
  output logic                             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcg_pkg::pcg_aphase_t aph, next_aph;
  logic [31:0] run_clock_config, next_run_clock_config;
  logic [31:0] run_gate_reg_one, next_run_gate_reg_one;
  logic [31:0] run_gate_reg_two, next_run_gate_reg_two;
  logic [31:0] sleep_gate_reg_one, next_sleep_gate_reg_one;
  logic [31:0] sleep_gate_reg_two, next_sleep_gate_reg_two;
  logic [31:0] deep_sleep_gate_reg_one, next_deep_sleep_gate_reg_one;
  logic [31:0] deep_sleep_gate_reg_two, next_deep_sleep_gate_reg_two;
  logic [1:0]  irq_stat, next_irq_stat;
  logic [1:0]  irq_mask, next_irq_mask;
  logic [31:0] next_hrdata;
  pcg_pkg::pcg_mode_t mode, next_mode;
  logic [pcg_pkg::UNIT_N-1:0] gate_req;
  logic        auto_gate_select;
  logic        wr_en;
  logic        rd_take;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign auto_gate_select = run_clock_config[pcg_pkg::AUTO_GATE_BIT];
  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // bus phases and register writes
  // ----------------------------------------------------------------
  always_comb begin
    next_aph.valid = hsel && hready && htrans[1];
    next_aph.write = hwrite;
    next_aph.addr  = {haddr[11:2], 2'b00};
    wr_en   = aph.valid && aph.write;
    rd_take = next_aph.valid && !hwrite;
    next_run_clock_config        = run_clock_config;
    next_run_gate_reg_one        = run_gate_reg_one;
    next_run_gate_reg_two        = run_gate_reg_two;
    next_sleep_gate_reg_one      = sleep_gate_reg_one;
    next_sleep_gate_reg_two      = sleep_gate_reg_two;
    next_deep_sleep_gate_reg_one = deep_sleep_gate_reg_one;
    next_deep_sleep_gate_reg_two = deep_sleep_gate_reg_two;
    next_irq_mask                = irq_mask;
    if (wr_en) begin
      case (aph.addr)
        pcg_pkg::OFF_RUN_CFG:  next_run_clock_config = hwdata & pcg_pkg::CFG_MASK;
        pcg_pkg::OFF_RUN_ONE:  next_run_gate_reg_one = hwdata & pcg_pkg::ONE_MASK;
        pcg_pkg::OFF_RUN_TWO:  next_run_gate_reg_two = hwdata & pcg_pkg::TWO_MASK;
        pcg_pkg::OFF_SLP_ONE:  next_sleep_gate_reg_one = hwdata & pcg_pkg::ONE_MASK;
        pcg_pkg::OFF_SLP_TWO:  next_sleep_gate_reg_two = hwdata & pcg_pkg::TWO_MASK;
        pcg_pkg::OFF_DSL_ONE:  next_deep_sleep_gate_reg_one = hwdata & pcg_pkg::ONE_MASK;
        pcg_pkg::OFF_DSL_TWO:  next_deep_sleep_gate_reg_two = hwdata & pcg_pkg::TWO_MASK;
        pcg_pkg::OFF_IRQ_MASK: next_irq_mask = hwdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data: taken from next values so a write just before is seen
  // ----------------------------------------------------------------
  always_comb begin
    next_hrdata = hrdata;
    if (rd_take) begin
      case (next_aph.addr)
        pcg_pkg::OFF_RUN_CFG:  next_hrdata = next_run_clock_config;
        pcg_pkg::OFF_RUN_ONE:  next_hrdata = next_run_gate_reg_one;
        pcg_pkg::OFF_RUN_TWO:  next_hrdata = next_run_gate_reg_two;
        pcg_pkg::OFF_SLP_ONE:  next_hrdata = next_sleep_gate_reg_one;
        pcg_pkg::OFF_SLP_TWO:  next_hrdata = next_sleep_gate_reg_two;
        pcg_pkg::OFF_DSL_ONE:  next_hrdata = next_deep_sleep_gate_reg_one;
        pcg_pkg::OFF_DSL_TWO:  next_hrdata = next_deep_sleep_gate_reg_two;
        pcg_pkg::OFF_IRQ_STAT: next_hrdata = {30'h0, irq_stat};
        pcg_pkg::OFF_IRQ_MASK: next_hrdata = {30'h0, next_irq_mask};
        default:               next_hrdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode selection and effective gate set
  // ----------------------------------------------------------------
  always_comb begin
    if (deep_sleep_mode && auto_gate_select) begin
      next_mode = pcg_pkg::PCG_DEEP;
    end else if (sleep_mode && auto_gate_select) begin
      next_mode = pcg_pkg::PCG_SLEEP;
    end else begin
      next_mode = pcg_pkg::PCG_RUN;
    end
    case (mode)
      pcg_pkg::PCG_SLEEP: gate_req = pcg_pkg::pcg_units(sleep_gate_reg_one, sleep_gate_reg_two);
      pcg_pkg::PCG_DEEP:  gate_req = pcg_pkg::pcg_units(deep_sleep_gate_reg_one, deep_sleep_gate_reg_two);
      default:            gate_req = pcg_pkg::pcg_units(run_gate_reg_one, run_gate_reg_two);
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt status: read clears, a new event wins over the clear
  // ----------------------------------------------------------------
  always_comb begin
    next_irq_stat = irq_stat;
    if (rd_take && next_aph.addr == pcg_pkg::OFF_IRQ_STAT) begin
      next_irq_stat = 2'h0;
    end
    if (bus_fault) begin
      next_irq_stat[pcg_pkg::STAT_FAULT] = 1'b1;
    end
    if (next_mode != mode) begin
      next_irq_stat[pcg_pkg::STAT_MODE] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph                     <= '0;
      hrdata                  <= 32'h00000000;
      run_clock_config        <= pcg_pkg::CFG_RESET;
      run_gate_reg_one        <= pcg_pkg::GATE_RESET;
      run_gate_reg_two        <= pcg_pkg::GATE_RESET;
      sleep_gate_reg_one      <= pcg_pkg::GATE_RESET;
      sleep_gate_reg_two      <= pcg_pkg::GATE_RESET;
      deep_sleep_gate_reg_one <= pcg_pkg::GATE_RESET;
      deep_sleep_gate_reg_two <= pcg_pkg::GATE_RESET;
      irq_stat                <= pcg_pkg::STAT_RESET;
      irq_mask                <= pcg_pkg::STAT_RESET;
      mode                    <= pcg_pkg::PCG_RUN;
    end else begin
      aph                     <= next_aph;
      hrdata                  <= next_hrdata;
      run_clock_config        <= next_run_clock_config;
      run_gate_reg_one        <= next_run_gate_reg_one;
      run_gate_reg_two        <= next_run_gate_reg_two;
      sleep_gate_reg_one      <= next_sleep_gate_reg_one;
      sleep_gate_reg_two      <= next_sleep_gate_reg_two;
      deep_sleep_gate_reg_one <= next_deep_sleep_gate_reg_one;
      deep_sleep_gate_reg_two <= next_deep_sleep_gate_reg_two;
      irq_stat                <= next_irq_stat;
      irq_mask                <= next_irq_mask;
      mode                    <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // per-unit enables and fault detection
  // ----------------------------------------------------------------
  // one register stage keeps enable edges aligned to hclk, at one cycle of latency
  pcg_gate_cell u_gate (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .gate_req    (gate_req),
    .unit_clk_en (unit_clk_en)
  );

  pcg_fault_check u_fault (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .unit_access (unit_access),
    .unit_clk_en (unit_clk_en),
    .bus_fault   (bus_fault)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_EN_FOLLOWS_REQ: assert property (##1 unit_clk_en == $past(gate_req))
    else $error("unit enable does not follow gate request");
  AST_ZERO_STOPS: assert property (!gate_req[0] |=> !unit_clk_en[0])
    else $error("unit clock still enabled after gate cleared");
  AST_FAULT: assert property ((unit_access & ~unit_clk_en) != '0 |=> bus_fault)
    else $error("access to stopped unit gave no fault");
  AST_NO_FAULT: assert property ((unit_access & ~unit_clk_en) == '0 |=> !bus_fault)
    else $error("fault without access to stopped unit");
  AST_RESERVED_ONE: assert property ((run_gate_reg_one & ~pcg_pkg::ONE_MASK) == 32'h0)
    else $error("reserved bit set in first gate register");
  AST_RESERVED_TWO: assert property ((run_gate_reg_two & ~pcg_pkg::TWO_MASK) == 32'h0)
    else $error("reserved bit set in second gate register");
  AST_RUN_WITHOUT_AUTO: assert property (!auto_gate_select |=> mode == pcg_pkg::PCG_RUN)
    else $error("sleep set used without auto gating");
  AST_DEEP_SET: assert property (deep_sleep_mode && auto_gate_select |=> mode == pcg_pkg::PCG_DEEP)
    else $error("deep sleep set not selected");
  AST_TWO_WRITE: assert property (wr_en && aph.addr == pcg_pkg::OFF_RUN_TWO
    |=> run_gate_reg_two == ($past(hwdata) & pcg_pkg::TWO_MASK))
    else $error("second run gate register not written");
  AST_TIMER_MAP: assert property (mode == pcg_pkg::PCG_RUN |-> gate_req[7:4] == run_gate_reg_one[19:16])
    else $error("timer gates mapped wrong");
  AST_PORT_MAP: assert property (mode == pcg_pkg::PCG_RUN |-> gate_req[16:8] ==
    {run_gate_reg_two[30], run_gate_reg_two[28], run_gate_reg_two[6:0]})
    else $error("port or ethernet gates mapped wrong");
  AST_SERIAL_MAP: assert property (mode == pcg_pkg::PCG_RUN |-> gate_req[3:0] ==
    {run_gate_reg_one[12], run_gate_reg_one[4], run_gate_reg_one[1:0]})
    else $error("serial gates mapped wrong");
  AST_STABLE_EN: assert property ($stable(gate_req) [*2] |-> $stable(unit_clk_en))
    else $error("enable changed without request change");

  // ----------------------------------------------------------------
  // checks: gate set selection by power mode
  // ----------------------------------------------------------------
  // expected vectors are spelled out bit by bit rather than through the package function,
  // so a slip in the shared unit mapping cannot check itself
  AST_SLEEP_SEL: assert property (sleep_mode && !deep_sleep_mode && auto_gate_select
    |=> mode == pcg_pkg::PCG_SLEEP)
    else $error("sleep set not selected");
  AST_DEEP_WINS: assert property (deep_sleep_mode |=> mode != pcg_pkg::PCG_SLEEP)
    else $error("sleep set chosen while deep sleep requested");
  AST_RUN_SEL: assert property (!sleep_mode && !deep_sleep_mode |=> mode == pcg_pkg::PCG_RUN)
    else $error("low power set used while running");
  AST_SLEEP_MAP: assert property (mode == pcg_pkg::PCG_SLEEP |-> gate_req ==
    {sleep_gate_reg_two[30], sleep_gate_reg_two[28], sleep_gate_reg_two[6:0],
     sleep_gate_reg_one[19:16], sleep_gate_reg_one[12], sleep_gate_reg_one[4], sleep_gate_reg_one[1:0]})
    else $error("sleep set not applied to the units");
  AST_DEEP_MAP: assert property (mode == pcg_pkg::PCG_DEEP |-> gate_req ==
    {deep_sleep_gate_reg_two[30], deep_sleep_gate_reg_two[28], deep_sleep_gate_reg_two[6:0],
     deep_sleep_gate_reg_one[19:16], deep_sleep_gate_reg_one[12],
     deep_sleep_gate_reg_one[4], deep_sleep_gate_reg_one[1:0]})
    else $error("deep sleep set not applied to the units");

  // ----------------------------------------------------------------
  // checks: register contents
  // ----------------------------------------------------------------
  // reserved positions must stay zero in every set, whatever software writes
  AST_RESERVED_LOW_ONE: assert property (((sleep_gate_reg_one | deep_sleep_gate_reg_one)
    & ~pcg_pkg::ONE_MASK) == 32'h0)
    else $error("reserved bit set in a low power first gate register");
  AST_RESERVED_LOW_TWO: assert property (((sleep_gate_reg_two | deep_sleep_gate_reg_two)
    & ~pcg_pkg::TWO_MASK) == 32'h0)
    else $error("reserved bit set in a low power second gate register");
  AST_CFG_ONLY_AUTO: assert property ((run_clock_config & ~pcg_pkg::CFG_MASK) == 32'h0)
    else $error("config register holds a bit other than auto gate select");
  AST_ONE_WRITE: assert property (wr_en && aph.addr == pcg_pkg::OFF_RUN_ONE
    |=> run_gate_reg_one == ($past(hwdata) & pcg_pkg::ONE_MASK))
    else $error("first run gate register not written");

  // ----------------------------------------------------------------
  // checks: status and interrupt
  // ----------------------------------------------------------------
  // an event in the cycle of its own read must survive the clear, or it is lost
  AST_FAULT_STICKY: assert property (bus_fault |=> irq_stat[pcg_pkg::STAT_FAULT])
    else $error("bus fault not recorded in status");
  AST_MODE_STICKY: assert property (next_mode != mode |=> irq_stat[pcg_pkg::STAT_MODE])
    else $error("mode change not recorded in status");
  AST_STAT_CLEAR: assert property (rd_take && next_aph.addr == pcg_pkg::OFF_IRQ_STAT && !bus_fault
    && next_mode == mode |=> irq_stat == 2'h0)
    else $error("status not cleared by its read");
  AST_IRQ_MASKED: assert property (irq_mask == 2'h0 |-> !irq)
    else $error("interrupt raised with every source masked");

  // ----------------------------------------------------------------
  // checks: enable latency
  // ----------------------------------------------------------------
  // a write lands at one edge and the enable follows at the next; units never see a half cycle
  // a mode change in the same window moves the set, so the check stands down then
  AST_RUN_TWO_LATENCY: assert property (wr_en && aph.addr == pcg_pkg::OFF_RUN_TWO
    && mode == pcg_pkg::PCG_RUN && next_mode == pcg_pkg::PCG_RUN
    |-> ##2 unit_clk_en[16:8] == {run_gate_reg_two[30], run_gate_reg_two[28], run_gate_reg_two[6:0]})
    else $error("second run gate write not applied within two cycles");

endmodule : pcg_top
`default_nettype wire

// ---- pcg_pkg.sv ----
// package of constants and types for the peripheral clock gating block
package pcg_pkg;

  // ----------------------------------------------------------------
  // register byte offsets within the system control space
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_RUN_CFG   = 12'h060;
  localparam logic [11:0] OFF_RUN_ONE   = 12'h104;
  localparam logic [11:0] OFF_RUN_TWO   = 12'h108;
  localparam logic [11:0] OFF_SLP_ONE   = 12'h114;
  localparam logic [11:0] OFF_SLP_TWO   = 12'h118;
  localparam logic [11:0] OFF_DSL_ONE   = 12'h124;
  localparam logic [11:0] OFF_DSL_TWO   = 12'h128;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h150;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h154;

  // ----------------------------------------------------------------
  // writable bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ONE_MASK      = 32'h000F1013;
  localparam logic [31:0] TWO_MASK      = 32'h5000007F;
  localparam int          AUTO_GATE_BIT = 27;
  localparam logic [31:0] CFG_MASK      = 32'h08000000;
  localparam logic [31:0] GATE_RESET    = 32'h00000000;
  localparam logic [31:0] CFG_RESET     = 32'h00000000;
  localparam int          STAT_FAULT    = 0;
  localparam int          STAT_MODE     = 1;
  localparam logic [1:0]  STAT_RESET    = 2'h0;

  // ----------------------------------------------------------------
  // unit vector layout
  // ----------------------------------------------------------------
  localparam int UNIT_N = 17;

  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP} pcg_mode_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } pcg_aphase_t;

  // async0,async1,sync_serial,two_wire,timer0..3,port_a..g,mac,phy
  function automatic logic [UNIT_N-1:0] pcg_units(input logic [31:0] one, input logic [31:0] two);
    pcg_units = {two[30], two[28], two[6:0], one[19:16], one[12], one[4], one[1:0]};
  endfunction : pcg_units

endpackage : pcg_pkg

// ---- pcg_gate_cell.sv ----
// registered, glitch-free clock enables for every gated unit
`timescale 1ns/1ns
`default_nettype none
module pcg_gate_cell (
  // clock and reset
  input  wire  logic                     hclk,
  input  wire  logic                     hresetn,
  // requested gates
  input  wire  logic [pcg_pkg::UNIT_N-1:0] gate_req,
  // enables toward the units
  output var   logic [pcg_pkg::UNIT_N-1:0] unit_clk_en
);

  // enables change only at an edge, so the downstream gate never sees a short pulse
  genvar g;
  generate
    for (g = 0; g < pcg_pkg::UNIT_N; g++) begin : g_cell
      logic next_en;
      always_comb begin
        next_en = gate_req[g];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          unit_clk_en[g] <= 1'b0;
        end else begin
          unit_clk_en[g] <= next_en;
        end
      end
    end
  endgenerate

endmodule : pcg_gate_cell
`default_nettype wire

// ---- pcg_fault_check.sv ----
// flags accesses that reach a unit whose clock is stopped
`timescale 1ns/1ns
`default_nettype none
module pcg_fault_check (
  // clock and reset
  input  wire  logic                       hclk,
  input  wire  logic                       hresetn,
  // accesses and current enables
  input  wire  logic [pcg_pkg::UNIT_N-1:0] unit_access,
  input  wire  logic [pcg_pkg::UNIT_N-1:0] unit_clk_en,
  // fault answer
  output var   logic                       bus_fault
);

  logic next_fault;

  always_comb begin
    next_fault = |(unit_access & ~unit_clk_en);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_fault <= 1'b0;
    end else begin
      bus_fault <= next_fault;
    end
  end

endmodule : pcg_fault_check
`default_nettype wire

// ---- pcg_dummy_never.sv ----
// intentionally empty
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- pcg_unit_model.sv ----
// partner model of the peripheral units reached over the system bus
`timescale 1ns/1ns
`default_nettype none
module pcg_unit_model (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // bench requests to touch a unit
  input  wire logic [pcg_pkg::UNIT_N-1:0] touch,
  // decoded unit selects toward the gating block
  output var  logic [pcg_pkg::UNIT_N-1:0] unit_access
);
  // ----------------------------------------------------------------
  // bus decode toward the units
  // ----------------------------------------------------------------
  logic [pcg_pkg::UNIT_N-1:0] next_unit_access;

  // one select cycle per request, like a single data phase; bench may touch a unit whose gate is closed
  always_comb begin
    next_unit_access = touch;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_access <= 17'h00000;
    end else begin
      unit_access <= next_unit_access;
    end
  end
endmodule : pcg_unit_model
`default_nettype wire

// ---- pcg_top_tb.sv ----
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ns
`default_nettype none
module pcg_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, sleep_mode, deep_sleep_mode, bus_fault, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [pcg_pkg::UNIT_N-1:0] unit_access, unit_clk_en, touch;
  int          n_errors = 0;
  int          samples_checked = 0;
  // unit order of the enable vector, as register bit (32 and up is the second register)
  int          ub[17] = '{0, 1, 4, 12, 16, 17, 18, 19, 32, 33, 34, 35, 36, 37, 38, 60, 62};

  always #10 hclk = ~hclk;

  pcg_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .unit_access(unit_access), .unit_clk_en(unit_clk_en), .bus_fault(bus_fault), .irq(irq));

  pcg_unit_model unit_u (.hclk(hclk), .hresetn(hresetn), .touch(touch), .unit_access(unit_access));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // single word transfer; waits on hready in both phases, no fixed latency assumed
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h00000000);
    chk(n, e, rd);
  endtask : rdc

  task automatic settle;
    repeat (2) @(posedge hclk);
    #1;
  endtask : settle

  task automatic chk_en(input logic [31:0] e);
    chk("unit enables", e, {15'h0000, unit_clk_en});
  endtask : chk_en

  // bench touches a unit; the fault answer stands for one cycle only
  task automatic pulse(input logic [pcg_pkg::UNIT_N-1:0] m, input logic e);
    touch <= m;
    @(posedge hclk);
    touch <= 17'h00000;
    @(posedge hclk);
    #1;
    chk("bus fault", {31'h0, e}, {31'h0, bus_fault});
    @(posedge hclk);
    #1;
    chk("bus fault end", 32'h0, {31'h0, bus_fault});
  endtask : pulse

  task automatic t_reset;
    rdc("run one", pcg_pkg::OFF_RUN_ONE, 32'h00000000);
    rdc("run two", pcg_pkg::OFF_RUN_TWO, 32'h00000000);
    rdc("sleep one", pcg_pkg::OFF_SLP_ONE, 32'h00000000);
    rdc("deep two", pcg_pkg::OFF_DSL_TWO, 32'h00000000);
    rdc("status", pcg_pkg::OFF_IRQ_STAT, 32'h00000000);
    chk_en(32'h00000000);
    chk("okay", 32'h0, {31'h0, hresp});
    chk("ready", 32'h1, {31'h0, hreadyout});
    chk("fault at reset", 32'h0, {31'h0, bus_fault});
    chk("irq at reset", 32'h0, {31'h0, irq});
  endtask : t_reset

  task automatic t_units;
    int          b;
    logic [31:0] e1, e2;
    e1 = 32'h00000000;
    e2 = 32'h00000000;
    for (int i = 0; i < 17; i++) begin
      b = ub[i];
      wr(pcg_pkg::OFF_RUN_ONE, (b < 32) ? (32'h1 << b) : 32'h0);
      wr(pcg_pkg::OFF_RUN_TWO, (b >= 32) ? (32'h1 << (b - 32)) : 32'h0);
      settle;
      chk_en(32'h1 << i);
      if (b < 32) e1 |= 32'h1 << b;
      else e2 |= 32'h1 << (b - 32);
    end
    wr(pcg_pkg::OFF_RUN_ONE, 32'hFFFFFFFF);
    wr(pcg_pkg::OFF_RUN_TWO, 32'hFFFFFFFF);
    rdc("run one bits", pcg_pkg::OFF_RUN_ONE, e1);
    rdc("run two bits", pcg_pkg::OFF_RUN_TWO, e2);
    settle;
    chk_en(32'h0001FFFF);
    wr(pcg_pkg::OFF_RUN_ONE, 32'h00000000);
    wr(pcg_pkg::OFF_RUN_TWO, 32'h00000000);
    settle;
    chk_en(32'h00000000);
  endtask : t_units

  task automatic t_fault;
    pulse(17'h00001, 1'b1);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(pcg_pkg::OFF_IRQ_MASK, 32'h00000003);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    rdc("fault status", pcg_pkg::OFF_IRQ_STAT, 32'h00000001);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(pcg_pkg::OFF_RUN_TWO, 32'h40000000);
    settle;
    pulse(17'h10000, 1'b0);
    pulse(17'h08000, 1'b1);
    rdc("fault again", pcg_pkg::OFF_IRQ_STAT, 32'h00000001);
  endtask : t_fault

  task automatic t_modes;
    wr(pcg_pkg::OFF_RUN_TWO, 32'h00000000);
    wr(pcg_pkg::OFF_SLP_TWO, 32'h00000001);
    wr(pcg_pkg::OFF_DSL_ONE, 32'h00000001);
    sleep_mode <= 1'b1;
    settle;
    chk_en(32'h00000000);
    xfer(pcg_pkg::OFF_RUN_CFG, 1'b0, 32'h0);
    wr(pcg_pkg::OFF_RUN_CFG, rd | 32'h08000000);
    rdc("auto select", pcg_pkg::OFF_RUN_CFG, 32'h08000000);
    settle;
    chk_en(32'h00000100);
    deep_sleep_mode <= 1'b1;
    settle;
    chk_en(32'h00000001);
    deep_sleep_mode <= 1'b0;
    sleep_mode <= 1'b0;
    settle;
    chk_en(32'h00000000);
    chk("mode irq", 32'h1, {31'h0, irq});
    xfer(pcg_pkg::OFF_IRQ_STAT, 1'b0, 32'h0);
    chk("mode event", 32'h00000002, rd & 32'h00000002);
    wr(pcg_pkg::OFF_RUN_CFG, 32'h00000000);
    // unmapped space reads zero and ignores writes
    wr(12'h200, 32'hFFFFFFFF);
    rdc("unmapped", 12'h200, 32'h00000000);
  endtask : t_modes

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    sleep_mode = 1'b0;
    deep_sleep_mode = 1'b0;
    touch = 17'h00000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_units;
    t_fault;
    t_modes;
    summarize;
  end

  // the whole run is under two hundred cycles; this limit only cuts a hang
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    summarize;
  end
endmodule : pcg_top_tb
`default_nettype wire
